// ==== rtl/eic_pkg.sv ====
// Purpose: constants for the extended interrupt controller
// Assumes: 8-bit registers on a 32-bit classic bus, index times four
// Notes:   printed offsets are register indices
package eic_pkg;
    // ************************************************************
    // register indices and byte addresses
    // ************************************************************
    localparam logic [7:0]  IDX_EXT_FLAG     = 8'h91;
    localparam logic [7:0]  IDX_PRIORITY_A   = 8'hb8;
    localparam logic [7:0]  IDX_EXT_CONTROL  = 8'hd8;
    localparam logic [7:0]  IDX_EXT_ENABLE   = 8'he8;
    localparam logic [7:0]  IDX_EXT_PRIORITY = 8'hf8;
    localparam logic [7:0]  IDX_BASIC_ENABLE = 8'ha8;
    localparam logic [7:0]  IDX_STATUS       = 8'h40;
    localparam logic [9:0]  ADR_EXT_FLAG     = {IDX_EXT_FLAG, 2'b00};
    localparam logic [9:0]  ADR_PRIORITY_A   = {IDX_PRIORITY_A, 2'b00};
    localparam logic [9:0]  ADR_EXT_CONTROL  = {IDX_EXT_CONTROL, 2'b00};
    localparam logic [9:0]  ADR_EXT_ENABLE   = {IDX_EXT_ENABLE, 2'b00};
    localparam logic [9:0]  ADR_EXT_PRIORITY = {IDX_EXT_PRIORITY, 2'b00};
    localparam logic [9:0]  ADR_BASIC_ENABLE = {IDX_BASIC_ENABLE, 2'b00};
    localparam logic [9:0]  ADR_STATUS       = {IDX_STATUS, 2'b00};

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_GLOBAL_GATE  = 7;
    localparam int BIT_RATE_DOUBLE  = 7;
    localparam int BIT_FLASHDBG_EN  = 5;
    localparam int BIT_FLASHDBG_FLG = 4;
    localparam int BIT_CLOCK_FLG    = 3;
    localparam int BIT_TMR3_FLG     = 7;
    localparam int BIT_CONV_FLG     = 6;
    localparam int BIT_TMR2_FLG     = 5;
    localparam int BIT_RADIO_FLG    = 4;
    localparam int BIT_EN_CLOCK     = 4;
    localparam int BIT_EN_TMR3      = 3;
    localparam int BIT_EN_CONV      = 2;
    localparam int BIT_EN_TMR2      = 1;
    localparam int BIT_EN_RADIO     = 0;

    // ************************************************************
    // reserved masks and reset values
    // ************************************************************
    localparam logic [7:0] ENABLE_ONES   = 8'he0;
    localparam logic [7:0] CONTROL_ONES  = 8'h40;
    localparam logic [7:0] CONTROL_RW    = 8'hb8;
    localparam logic [7:0] FLAG_ONES     = 8'h08;
    localparam logic [7:0] FLAG_RW       = 8'hf0;
    localparam logic [7:0] PRIO_A_ONES   = 8'h80;
    localparam logic [7:0] EXT_PRIO_ONES = 8'he0;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam int         NUM_SRC       = 12;
    localparam logic [3:0] NO_SOURCE     = 4'hf;

    // ************************************************************
    // priority levels, one-hot encoded
    // ************************************************************
    typedef enum logic [3:0] {
        EIC_LVL_NONE    = 4'b0001,
        EIC_LVL_LOW     = 4'b0010,
        EIC_LVL_HIGH    = 4'b0100,
        EIC_LVL_HIGHEST = 4'b1000
    } eic_level_type;
endpackage

// ==== rtl/eic_ctrl.sv ====
// Purpose: extended interrupt enables, flags and two-stage arbitration
// Assumes: classic wishbone slave, one ack cycle after request
// Notes:   core sequencer gives instruction boundary and service strobes
//
// Operation
// RQ1 - per-source extended enables also need global gate
// RQ2 - converter or cipher share one gated request
// RQ3 - control bit 7 doubles uart1 rate
// RQ4 - control bit 5 enables flash/debug alone
// RQ5 - flash write done or trap sets bit4
// RQ6 - software ones set flags; software clears
// RQ7 - clock source request sets control bit 3
// RQ8 - timer3 sets flag bit7, timer2 bit5
// RQ9 - radio request sets flag bit 4
// RQ10 - conv/cipher flag set only when locally enabled
// RQ11 - reserved bits read fixed constants
// RQ12 - priority bit 5 is plain read/write storage
// RQ13 - level compared first, then natural order
// RQ14 - only flash/debug reaches highest level
// RQ15 - equal level: smallest natural number wins
// RQ16 - preempt only by strictly higher level
// RQ17 - basic priority bits map basic sources
// RQ18 - extended priority bits map extended sources
// RQ19 - cleared global gate masks all but flash/debug
// RQ20 - natural numbers 0 to 11 fixed order
// RQ21 - hold off one instruction after sensitive ops
// RQ22 - hardware set wins over software clear
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module eic_ctrl (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // peripheral requests, one-cycle pulses
    input  wire logic        flash_write_done,
    input  wire logic        trap_exec,
    input  wire logic        clock_src_req,
    input  wire logic        tmr3_req,
    input  wire logic        tmr2_req,
    input  wire logic        radio_req,
    input  wire logic        converter_done_flag,
    input  wire logic        cipher_done_flag,
    input  wire logic        converter_local_en,
    input  wire logic        cipher_local_en,
    // basic sources, pending levels in natural order 1..6
    input  wire logic [5:0]  basic_pending,
    // core sequencer
    input  wire logic        instr_boundary,
    input  wire logic        sensitive_instr,
    input  wire logic        return_from_isr_op,
    input  wire logic        vector_taken,
    // outputs
    output logic             irq_take,
    output logic      [3:0]  irq_source,
    output logic             uart1_rate_double,
    output logic             in_service
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] ext_flag_reg;
    logic [7:0] priority_reg_a;
    logic [7:0] ext_control_reg;
    logic [7:0] ext_enable_reg;
    logic [7:0] ext_priority_reg;
    logic [7:0] basic_enable_reg;
    logic       wr_stb;
    logic       wr_lane;
    logic       rd_hit;
    logic [7:0] rd_byte;

    assign wr_stb  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o;
    assign wr_lane = wr_stb && wb_sel_i[0];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            priority_reg_a   <= eic_pkg::REG_RESET;
            ext_enable_reg   <= eic_pkg::REG_RESET;
            ext_priority_reg <= eic_pkg::REG_RESET;
            basic_enable_reg <= eic_pkg::REG_RESET;
        end else if (wr_lane) begin
            case (wb_adr_i)
                eic_pkg::ADR_PRIORITY_A:   priority_reg_a   <= wb_dat_i[7:0]; // RQ12 RQ17
                eic_pkg::ADR_EXT_ENABLE:   ext_enable_reg   <= wb_dat_i[7:0];
                eic_pkg::ADR_EXT_PRIORITY: ext_priority_reg <= wb_dat_i[7:0]; // RQ18
                eic_pkg::ADR_BASIC_ENABLE: basic_enable_reg <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // flags: hardware set wins over software write
    // ************************************************************
    logic       conv_set;
    logic [7:0] flag_hw_set;
    logic [7:0] ctl_hw_set;

    assign conv_set = (converter_done_flag && converter_local_en)
                    || (cipher_done_flag && cipher_local_en);            // RQ2 RQ10

    always_comb begin
        flag_hw_set = 8'h00;
        ctl_hw_set  = 8'h00;
        flag_hw_set[eic_pkg::BIT_TMR3_FLG]  = tmr3_req;                  // RQ8
        flag_hw_set[eic_pkg::BIT_TMR2_FLG]  = tmr2_req;                  // RQ8
        flag_hw_set[eic_pkg::BIT_RADIO_FLG] = radio_req;                 // RQ9
        flag_hw_set[eic_pkg::BIT_CONV_FLG]  = conv_set;                  // RQ10
        ctl_hw_set[eic_pkg::BIT_FLASHDBG_FLG] = flash_write_done || trap_exec; // RQ5
        ctl_hw_set[eic_pkg::BIT_CLOCK_FLG]    = clock_src_req;           // RQ7
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_flag_reg <= eic_pkg::REG_RESET;
        end else if (wr_lane && wb_adr_i == eic_pkg::ADR_EXT_FLAG) begin
            ext_flag_reg <= (wb_dat_i[7:0] & eic_pkg::FLAG_RW) | flag_hw_set; // RQ6 RQ22
        end else begin
            ext_flag_reg <= ext_flag_reg | flag_hw_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_control_reg <= eic_pkg::REG_RESET;
        end else if (wr_lane && wb_adr_i == eic_pkg::ADR_EXT_CONTROL) begin
            ext_control_reg <= (wb_dat_i[7:0] & eic_pkg::CONTROL_RW) | ctl_hw_set; // RQ6 RQ22
        end else begin
            ext_control_reg <= ext_control_reg | ctl_hw_set;
        end
    end

    assign uart1_rate_double = ext_control_reg[eic_pkg::BIT_RATE_DOUBLE]; // RQ3

    // ************************************************************
    // pending requests in natural order 0..11
    // ************************************************************
    logic                          global_gate;
    logic [eic_pkg::NUM_SRC-1:0]   pend;
    logic [eic_pkg::NUM_SRC-1:0]   high_lvl;
    logic [4:0]                    ext_en;
    logic [4:0]                    ext_req;

    assign global_gate = basic_enable_reg[eic_pkg::BIT_GLOBAL_GATE];
    assign ext_en      = ext_enable_reg[4:0] & {5{global_gate}};         // RQ1 RQ19
    assign ext_req     = {ext_control_reg[eic_pkg::BIT_CLOCK_FLG],
                          ext_flag_reg[eic_pkg::BIT_TMR3_FLG],
                          ext_flag_reg[eic_pkg::BIT_CONV_FLG],
                          ext_flag_reg[eic_pkg::BIT_TMR2_FLG],
                          ext_flag_reg[eic_pkg::BIT_RADIO_FLG]};

    always_comb begin
        pend[0]     = ext_control_reg[eic_pkg::BIT_FLASHDBG_FLG]
                    && ext_control_reg[eic_pkg::BIT_FLASHDBG_EN];        // RQ4 RQ19
        pend[6:1]   = basic_pending & {basic_enable_reg[6], basic_enable_reg[4:0]}
                    & {6{global_gate}};                                  // RQ17 RQ19
        pend[11:7]  = ext_req & ext_en;                                  // RQ1 RQ20
        high_lvl[0] = 1'b0;
        high_lvl[6:1] = {priority_reg_a[6], priority_reg_a[4:0]};        // RQ17
        high_lvl[11:7] = ext_priority_reg[4:0];                          // RQ18
    end

    // ************************************************************
    // two-stage arbitration
    // ************************************************************
    logic [3:0]             best_src;
    eic_pkg::eic_level_type best_lvl;

    always_comb begin
        best_src = eic_pkg::NO_SOURCE;
        best_lvl = eic_pkg::EIC_LVL_NONE;
        if (pend[0]) begin
            best_src = 4'h0;                                             // RQ14
            best_lvl = eic_pkg::EIC_LVL_HIGHEST;
        end else begin
            for (int i = eic_pkg::NUM_SRC - 1; i >= 1; i--) begin
                if (pend[i] && high_lvl[i]) begin                        // RQ13 RQ15
                    best_src = 4'(i);
                    best_lvl = eic_pkg::EIC_LVL_HIGH;
                end
            end
            if (best_lvl == eic_pkg::EIC_LVL_NONE) begin
                for (int i = eic_pkg::NUM_SRC - 1; i >= 1; i--) begin
                    if (pend[i]) begin                                   // RQ15
                        best_src = 4'(i);
                        best_lvl = eic_pkg::EIC_LVL_LOW;
                    end
                end
            end
        end
    end

    // ************************************************************
    // service levels: one active flag per level
    // ************************************************************
    logic [2:0] active_lvl;  // bit0 low, bit1 high, bit2 highest
    logic       hold_off;
    logic       beats;

    always_comb begin
        case (best_lvl)
            eic_pkg::EIC_LVL_HIGHEST: beats = (active_lvl[2] == 1'b0);   // RQ16
            eic_pkg::EIC_LVL_HIGH:    beats = (active_lvl[2:1] == 2'b00);
            eic_pkg::EIC_LVL_LOW:     beats = (active_lvl == 3'b000);
            default:                  beats = 1'b0;
        endcase
    end

    // after sensitive ops the next boundary is skipped
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hold_off <= 1'b0;
        end else if (instr_boundary) begin
            hold_off <= sensitive_instr || return_from_isr_op;           // RQ21
        end
    end

    assign irq_take   = instr_boundary && !hold_off && !sensitive_instr
                      && !return_from_isr_op && beats;                   // RQ21
    assign in_service = |active_lvl;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_source <= eic_pkg::NO_SOURCE;
        end else if (irq_take) begin
            irq_source <= best_src;
        end
    end

    // level kept from the take; a flag cleared before entry cannot lose it
    eic_pkg::eic_level_type taken_lvl;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            taken_lvl <= eic_pkg::EIC_LVL_NONE;
        end else if (irq_take) begin
            taken_lvl <= best_lvl;                                       // RQ16
        end
    end

    // return clears the highest active level; vector entry sets it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            active_lvl <= 3'b000;
        end else if (vector_taken) begin
            case (taken_lvl)
                eic_pkg::EIC_LVL_HIGHEST: active_lvl[2] <= 1'b1;
                eic_pkg::EIC_LVL_HIGH:    active_lvl[1] <= 1'b1;
                eic_pkg::EIC_LVL_LOW:     active_lvl[0] <= 1'b1;
                default: ;
            endcase
        end else if (return_from_isr_op && instr_boundary) begin
            if (active_lvl[2]) begin
                active_lvl[2] <= 1'b0;
            end else if (active_lvl[1]) begin
                active_lvl[1] <= 1'b0;
            end else begin
                active_lvl[0] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // bus read and ack
    // ************************************************************
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (wb_adr_i)
            eic_pkg::ADR_EXT_FLAG:     rd_byte = (ext_flag_reg & eic_pkg::FLAG_RW)
                                               | eic_pkg::FLAG_ONES;     // RQ11
            eic_pkg::ADR_PRIORITY_A:   rd_byte = priority_reg_a | eic_pkg::PRIO_A_ONES;
            eic_pkg::ADR_EXT_CONTROL:  rd_byte = (ext_control_reg & eic_pkg::CONTROL_RW)
                                               | eic_pkg::CONTROL_ONES;  // RQ11
            eic_pkg::ADR_EXT_ENABLE:   rd_byte = ext_enable_reg | eic_pkg::ENABLE_ONES;
            eic_pkg::ADR_EXT_PRIORITY: rd_byte = ext_priority_reg | eic_pkg::EXT_PRIO_ONES;
            eic_pkg::ADR_BASIC_ENABLE: rd_byte = basic_enable_reg;
            eic_pkg::ADR_STATUS:       rd_byte = {in_service, 3'b000, best_src};
            default:                   rd_hit  = 1'b0;
        endcase
    end

    // single registered answer one cycle after request; unmapped addresses get err
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && rd_hit;
            wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !rd_hit;
        end
    end

    // read byte refreshed every cycle, steady while ack stands
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end
endmodule

// ==== tb/eic_core_model.sv ====
// Purpose: core sequencer stand-in, instruction ends and vector entry
// Assumes: bench asks for one instruction end at a time
// Notes:   vector entry follows a take by one cycle, as a real fetch would
`timescale 1ns/1ps
module eic_core_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // bench command: 0 idle, 1 plain, 2 sensitive write, 3 return
    input  wire logic [1:0] op,
    input  wire logic       irq_take,
    // sequencer outputs
    output logic            instr_boundary,
    output logic            sensitive_instr,
    output logic            return_from_isr_op,
    output logic            vector_taken
);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            instr_boundary     <= 1'b0;
            sensitive_instr    <= 1'b0;
            return_from_isr_op <= 1'b0;
            vector_taken       <= 1'b0;
        end else begin
            instr_boundary     <= (op != 2'd0);
            sensitive_instr    <= (op == 2'd2);
            return_from_isr_op <= (op == 2'd3);
            vector_taken       <= irq_take;
        end
    end
endmodule

// ==== tb/eic_ctrl_sva.sv ====
// Purpose: port-level checks of the extended interrupt controller
// Assumes: one clock, synchronous active-high reset
// Notes:   flag contents are judged by the bench through reads
`timescale 1ns/1ps
module eic_ctrl_sva (
    // clock, reset and bus
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // sequencer and outputs
    input wire logic        instr_boundary,
    input wire logic        sensitive_instr,
    input wire logic        return_from_isr_op,
    input wire logic        vector_taken,
    input wire logic        irq_take,
    input wire logic [3:0]  irq_source,
    input wire logic        uart1_rate_double,
    input wire logic        in_service
);
    logic mapped;
    logic rd_ack;
    logic held;
    assign mapped = wb_adr_i inside {eic_pkg::ADR_EXT_FLAG, eic_pkg::ADR_PRIORITY_A,
        eic_pkg::ADR_EXT_CONTROL, eic_pkg::ADR_EXT_ENABLE, eic_pkg::ADR_EXT_PRIORITY,
        eic_pkg::ADR_BASIC_ENABLE, eic_pkg::ADR_STATUS};
    assign rd_ack = wb_ack_o && !wb_we_i;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // last boundary was a return or a sensitive write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            held <= 1'b0;
        end else if (instr_boundary) begin
            held <= sensitive_instr || return_from_isr_op;
        end
    end
    a_ack_next_cycle: assert property ($rose(wb_stb_i) && wb_cyc_i && mapped
        |=> wb_ack_o) else $error("no ack one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_err_unmapped: assert property ($rose(wb_stb_i) && wb_cyc_i && !mapped
        |=> wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
    a_enable_ones: assert property (rd_ack && wb_adr_i == eic_pkg::ADR_EXT_ENABLE
        |-> wb_dat_o[31:5] == 27'h7) else $error("enable reserved bits wrong");
    a_flag_fixed: assert property (rd_ack && wb_adr_i == eic_pkg::ADR_EXT_FLAG
        |-> wb_dat_o[3:0] == 4'h8) else $error("flag reserved bits wrong");
    a_rate_follow: assert property (wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == eic_pkg::ADR_EXT_CONTROL
        |=> uart1_rate_double == $past(wb_dat_i[7])) else $error("rate double not written");
    a_take_on_edge: assert property (irq_take |-> instr_boundary && !held
        && !sensitive_instr && !return_from_isr_op)
        else $error("take outside a clean boundary");
    a_source_valid: assert property (irq_take |=> irq_source < 4'hc)
        else $error("latched source out of range");
    a_service_entry: assert property (vector_taken |=> in_service)
        else $error("vector entry without service");
    a_reset_state: assert property (disable iff (1'b0) sys_rst
        |=> irq_source == 4'hf && !in_service
        && !uart1_rate_double && !wb_ack_o && !wb_err_o) else $error("reset state wrong");
    c_take: cover property (irq_take);
    c_preempt: cover property (irq_take && in_service);
    c_refused: cover property (wb_err_o);
endmodule
bind eic_ctrl eic_ctrl_sva i_eic_ctrl_sva (.core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .instr_boundary,
    .sensitive_instr, .return_from_isr_op, .vector_taken, .irq_take, .irq_source,
    .uart1_rate_double, .in_service);

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the extended interrupt controller
// Assumes: one answer per bus request, instruction ends from the core model
// Notes:   drivers queue expectations, one monitor compares them
`timescale 1ns/1ps
module testbench;
    logic        core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, src_due;
    logic [9:0]  wb_adr_i, hw;
    logic [3:0]  wb_sel_i, irq_source, src_exp;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        wb_ack_o, wb_err_o, irq_take, uart1_rate_double, in_service;
    logic        instr_boundary, sensitive_instr, return_from_isr_op, vector_taken;
    logic [1:0]  op;
    logic [5:0]  bp;
    logic [8:0]  rd_q[$];
    logic [4:0]  irq_q[$];
    logic [9:0]  adr_t[5], hv_t[9];
    logic [7:0]  ones_t[5], rw_t[5], he_t[9], v;
    int          err_total, total_checks, cycles;
    eic_ctrl i_eic_ctrl (.core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .flash_write_done(hw[9]),
        .trap_exec(hw[8]), .clock_src_req(hw[7]), .tmr3_req(hw[6]), .tmr2_req(hw[5]),
        .radio_req(hw[4]), .converter_done_flag(hw[3]), .cipher_done_flag(hw[2]),
        .converter_local_en(hw[1]), .cipher_local_en(hw[0]), .basic_pending(bp),
        .instr_boundary, .sensitive_instr, .return_from_isr_op, .vector_taken,
        .irq_take, .irq_source, .uart1_rate_double, .in_service);
    eic_core_model i_eic_core_model (.core_clk, .sys_rst, .op, .irq_take, .instr_boundary,
        .sensitive_instr, .return_from_isr_op, .vector_taken);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hw stands for the first request cycle only, so it meets the write edge alone
    task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d,
                       input logic [8:0] e, input logic [9:0] h);
        if (!w) rd_q.push_back(e);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_sel_i <= 4'h1;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        hw       <= h;
        do begin
            @(posedge core_clk);
            hw <= 10'h0;
        end while (!(wb_ack_o || wb_err_o));
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 9'h0, 10'h0);
    endtask
    task automatic rd(input logic [9:0] a, input logic [8:0] e);
        bus(a, 1'b0, 8'h0, e, 10'h0);
    endtask
    task automatic pulse(input logic [9:0] h);
        hw <= h;
        @(posedge core_clk);
        hw <= 10'h0;
        @(posedge core_clk);
    endtask
    task automatic step(input logic [1:0] o, input logic [4:0] q);
        irq_q.push_back(q);
        op <= o;
        @(posedge core_clk);
        op <= 2'd0;
        repeat (3) @(posedge core_clk);
    endtask
    // ************************************
    // monitor and hang guard
    // ************************************
    always @(posedge core_clk) begin
        logic [8:0] e;
        logic [4:0] q;
        if (src_due) check(irq_source === src_exp, "latched source");
        if ((wb_ack_o || wb_err_o) && !wb_we_i) begin
            e = rd_q.pop_front();
            check(e[8] ? wb_err_o === 1'b1 : wb_dat_o === {24'h0, e[7:0]},
                  "read data");
        end
        if (instr_boundary === 1'b1) begin
            q = irq_q.pop_front();
            check(irq_take === q[4], "take decision");
            src_due <= q[4];
            src_exp <= q[3:0];
        end else begin
            src_due <= 1'b0;
        end
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            results();
        end
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, src_due, op, hw, wb_sel_i, bp} = '0;
        wb_adr_i = 10'h0;
        wb_dat_i = 32'h0;
        adr_t = '{eic_pkg::ADR_EXT_FLAG, eic_pkg::ADR_PRIORITY_A, eic_pkg::ADR_EXT_CONTROL,
                  eic_pkg::ADR_EXT_ENABLE, eic_pkg::ADR_EXT_PRIORITY};
        ones_t = '{eic_pkg::FLAG_ONES, eic_pkg::PRIO_A_ONES, eic_pkg::CONTROL_ONES,
                   eic_pkg::ENABLE_ONES, eic_pkg::EXT_PRIO_ONES};
        rw_t = '{eic_pkg::FLAG_RW, 8'h7f, eic_pkg::CONTROL_RW, 8'h1f, 8'h1f};
        hv_t = '{10'h040, 10'h020, 10'h010, 10'h00a, 10'h005, 10'h008, 10'h080, 10'h200, 10'h100};
        he_t = '{8'h88, 8'h28, 8'h18, 8'h48, 8'h48, 8'h08, 8'h48, 8'h50, 8'h50};
        sys_rst = 1'b1;
        void'($urandom(32351));
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) rd(adr_t[i], {1'b0, ones_t[i]});
        rd(10'h004, 9'h100);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            v = 8'($urandom);
            wr(adr_t[i], v);
            rd(adr_t[i], {1'b0, (v & rw_t[i]) | ones_t[i]});
            if (i == 2) check(uart1_rate_double === v[7], "rate double");
            wr(adr_t[i], 8'h00);
        end
        $display("test register access done");
        for (int i = 0; i < 9; i++) begin
            pulse(hv_t[i]);
            rd(i < 6 ? eic_pkg::ADR_EXT_FLAG : eic_pkg::ADR_EXT_CONTROL, {1'b0, he_t[i]});
            wr(i < 6 ? eic_pkg::ADR_EXT_FLAG : eic_pkg::ADR_EXT_CONTROL, 8'h00);
        end
        bus(eic_pkg::ADR_EXT_FLAG, 1'b1, 8'h00, 9'h0, 10'h040);
        rd(eic_pkg::ADR_EXT_FLAG, 9'h088);
        wr(eic_pkg::ADR_EXT_FLAG, 8'h00);
        $display("test flag setting done");
        wr(eic_pkg::ADR_EXT_ENABLE, 8'h1f);
        wr(eic_pkg::ADR_EXT_FLAG, 8'h30);
        step(2'd1, 5'h00);
        wr(eic_pkg::ADR_BASIC_ENABLE, 8'h80);
        step(2'd2, 5'h00);
        step(2'd1, 5'h00);
        step(2'd1, 5'h17);
        step(2'd1, 5'h00);
        wr(eic_pkg::ADR_EXT_PRIORITY, 8'h02);
        step(2'd1, 5'h18);
        wr(eic_pkg::ADR_EXT_CONTROL, 8'h30);
        wr(eic_pkg::ADR_BASIC_ENABLE, 8'h00);
        step(2'd1, 5'h10);
        wr(eic_pkg::ADR_EXT_CONTROL, 8'h20);
        step(2'd3, 5'h00);
        step(2'd1, 5'h00);
        wr(eic_pkg::ADR_BASIC_ENABLE, 8'h80);
        step(2'd1, 5'h00);
        step(2'd3, 5'h00);
        step(2'd1, 5'h00);
        step(2'd1, 5'h18);
        $display("test arbitration done");
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        wr(eic_pkg::ADR_BASIC_ENABLE, 8'hc1);
        bp <= 6'h21;
        step(2'd1, 5'h11);
        wr(eic_pkg::ADR_PRIORITY_A, 8'h40);
        step(2'd1, 5'h16);
        $display("test basic sources done");
        results();
    end
endmodule
